//--- input_sync.sv
`timescale 1ns/1ps
module input_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Raw level and its synchronised copy
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff  <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : input_sync

//--- pacc_pkg.sv
package pacc_pkg;

   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int IDX_W  = 6;
   localparam int DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_MASK  = 6'h24;
   localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h25;
   localparam logic [IDX_W-1:0] IDX_CTRL  = 6'h26;
   localparam logic [IDX_W-1:0] IDX_COUNT = 6'h27;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int OVF_BIT  = 5;
   localparam int EDGE_BIT = 4;
   localparam int EN_BIT   = 6;
   localparam int MODE_BIT = 5;
   localparam int POL_BIT  = 4;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]        MASK_RST  = 8'h00;
   localparam logic [7:0]        FLAGS_RST = 8'h00;
   localparam logic [7:0]        CTRL_RST  = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST  = 32'h0000_0000;

   // ****************************************
   // Counts
   // ****************************************
   localparam int          GATE_DIV   = 64;
   localparam int          PRESCALE_W = 6;
   localparam logic [7:0]  COUNT_TOP  = 8'hFF;

   typedef enum logic [0:0] {
      MODE_EVENT = 1'b0,
      MODE_GATED = 1'b1
   } acc_mode_t;

endpackage : pacc_pkg

//--- pulse_accumulator_counter.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// R1 - An eight-bit count register, read or written anytime, untouched by reset.
// R2 - Increments and bus reads never collide; reads see a settled value.
// R3 - Overflow flag sets whenever the count wraps from all ones to zero.
// R4 - Writing one to flag bit 5 clears overflow; zero leaves it.
// R5 - Overflow enable never changes the flag; cleared enable blocks its interrupt.
// R6 - With overflow enable set, a set overflow flag requests an interrupt.
// R7 - Input-edge flag sets on each selected edge of the accumulator input.
// R8 - Writing one to flag bit 4 clears the edge flag; zero leaves it.
// R9 - Edge enable never changes the edge flag; cleared enable blocks its interrupt.
// R10 - With edge enable set, a set edge flag requests an interrupt.
// R11 - Enables sit in the mask register at the same bits as their flags.
// R12 - Software must clear the overflow flag before leaving its handler.
// R13 - Software must clear the edge flag before leaving its handler.
// R14 - The system enable bit gates the whole accumulator.
// R15 - Mode and polarity bits choose event edge or gated inhibit level.
// R16 - Gated mode counts a free-running one-in-sixty-four tick while input is active.
// R17 - The event source toggles no faster than half the clock rate.
// R18 - The input passes two flip-flops before edge detection or gating.
module pulse_accumulator_counter (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rstn,
   // Wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [pacc_pkg::ADDR_W-1:0]   wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [pacc_pkg::DATA_W-1:0]   wb_dat_i,
   output logic      [pacc_pkg::DATA_W-1:0]   wb_dat_o,
   output logic                               wb_ack_o,
   // Pulse input pin
   input  wire logic                          accumulator_input_pin,
   // Interrupt
   output logic                               irq_o
);
   import pacc_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic                  pin_sync;
   logic                  pin_prev_ff;
   logic [7:0]            accumulator_count_ff;
   logic [7:0]            nxt_accumulator_count;
   logic [7:0]            timer_interrupt_mask_two_ff;
   logic [7:0]            timer_interrupt_flags_two_ff;
   logic [7:0]            nxt_flags;
   logic [7:0]            ctrl_ff;
   logic [PRESCALE_W-1:0] prescale_ff;
   logic                  gate_tick;
   logic                  accumulator_system_enable;
   acc_mode_t             accumulator_mode_select;
   logic                  edge_polarity_select;
   logic                  edge_hit;
   logic                  gate_open;
   logic                  count_inc;
   logic                  wrap;
   logic                  overflow_flag;
   logic                  input_edge_flag;
   logic                  overflow_irq_enable;
   logic                  input_edge_irq_enable;
   logic                  req;
   logic                  wr_go;
   logic [IDX_W-1:0]      idx;
   logic                  hit_mask;
   logic                  hit_flags;
   logic                  hit_ctrl;
   logic                  hit_count;
   logic [7:0]            rd_byte;
   logic [7:0]            flag_clear;
   logic [7:0]            flag_set;
   logic                  count_loaded_ff;

   // ****************************************
   // Input synchroniser
   // ****************************************
   input_sync u_pin_sync (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .async_in (accumulator_input_pin), // R18
      .sync_out (pin_sync)
   );

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_prev_ff <= 1'b0;
      end else begin
         pin_prev_ff <= pin_sync;
      end
   end

   // ****************************************
   // Control fields
   // ****************************************
   assign accumulator_system_enable = ctrl_ff[EN_BIT];
   assign accumulator_mode_select   = acc_mode_t'(ctrl_ff[MODE_BIT]);
   assign edge_polarity_select      = ctrl_ff[POL_BIT];
   assign overflow_irq_enable       = timer_interrupt_mask_two_ff[OVF_BIT];  // R11
   assign input_edge_irq_enable     = timer_interrupt_mask_two_ff[EDGE_BIT]; // R11
   assign overflow_flag             = timer_interrupt_flags_two_ff[OVF_BIT];
   assign input_edge_flag           = timer_interrupt_flags_two_ff[EDGE_BIT];

   // ****************************************
   // Gate clock prescaler
   // ****************************************
   // Free running so the gated tick phase is independent of the enable
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         prescale_ff <= '0;
      end else begin
         prescale_ff <= prescale_ff + 1'b1;
      end
   end

   assign gate_tick = (prescale_ff == PRESCALE_W'(GATE_DIV - 1)); // R16

   // ****************************************
   // Edge and gate decode
   // ****************************************
   // One sample per cycle: edges closer than two clocks may be missed
   always_comb begin
      edge_hit = 1'b0;
      if (accumulator_system_enable) begin // R14
         if (edge_polarity_select) begin
            edge_hit = pin_sync & ~pin_prev_ff; // R15 R17
         end else begin
            edge_hit = ~pin_sync & pin_prev_ff; // R15 R17
         end
      end
   end

   // Polarity 0 inhibits on low, 1 inhibits on high
   assign gate_open = edge_polarity_select ? ~pin_sync : pin_sync; // R15

   always_comb begin
      count_inc = 1'b0;
      if (accumulator_system_enable) begin // R14
         unique case (accumulator_mode_select)
            MODE_EVENT: begin
               count_inc = edge_hit; // R15
            end
            MODE_GATED: begin
               count_inc = gate_tick & gate_open; // R16
            end
         endcase
      end
   end

   // ****************************************
   // Bus decode
   // ****************************************
   assign req       = wb_cyc_i & wb_stb_i;
   assign idx       = wb_adr_i[ADDR_W-1:2];
   assign hit_mask  = (idx == IDX_MASK);
   assign hit_flags = (idx == IDX_FLAGS);
   assign hit_ctrl  = (idx == IDX_CTRL);
   assign hit_count = (idx == IDX_COUNT);
   // Writes land on the edge that the master samples ack
   assign wr_go     = req & wb_we_i & wb_ack_o & wb_sel_i[0];

   always_comb begin
      rd_byte = 8'h00;
      if (hit_mask) begin
         rd_byte = timer_interrupt_mask_two_ff;
      end else if (hit_flags) begin
         rd_byte = timer_interrupt_flags_two_ff;
      end else if (hit_ctrl) begin
         rd_byte = ctrl_ff;
      end else if (hit_count) begin
         rd_byte = accumulator_count_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   // Read data is the value held before this edge's increment lands
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wb_dat_o <= DATA_RST;
      end else if (req & ~wb_ack_o) begin
         wb_dat_o <= {24'h00_0000, rd_byte}; // R2
      end
   end

   // ****************************************
   // Count register
   // ****************************************
   assign wrap = count_inc & (accumulator_count_ff == COUNT_TOP);

   always_comb begin
      nxt_accumulator_count = accumulator_count_ff;
      if (wr_go & hit_count) begin
         nxt_accumulator_count = wb_dat_i[7:0]; // R1
      end else if (count_inc) begin
         nxt_accumulator_count = accumulator_count_ff + 8'h01;
      end
   end

   // No reset: the count survives reset by design
   always_ff @(posedge ref_clk) begin
      accumulator_count_ff <= nxt_accumulator_count; // R1
   end

   // Count is unknown until loaded, so checks on its value wait for a load
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_loaded_ff <= 1'b0;
      end else if (wr_go & hit_count) begin
         count_loaded_ff <= 1'b1;
      end
   end

   // ****************************************
   // Mask and control registers
   // ****************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_interrupt_mask_two_ff <= MASK_RST;
      end else if (wr_go & hit_mask) begin
         timer_interrupt_mask_two_ff[OVF_BIT]  <= wb_dat_i[OVF_BIT];  // R11
         timer_interrupt_mask_two_ff[EDGE_BIT] <= wb_dat_i[EDGE_BIT]; // R11
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_go & hit_ctrl) begin
         ctrl_ff[EN_BIT]   <= wb_dat_i[EN_BIT];
         ctrl_ff[MODE_BIT] <= wb_dat_i[MODE_BIT];
         ctrl_ff[POL_BIT]  <= wb_dat_i[POL_BIT];
      end
   end

   // ****************************************
   // Flags
   // ****************************************
   always_comb begin
      flag_clear = 8'h00;
      flag_set   = 8'h00;
      if (wr_go & hit_flags) begin
         flag_clear[OVF_BIT]  = wb_dat_i[OVF_BIT];  // R4
         flag_clear[EDGE_BIT] = wb_dat_i[EDGE_BIT]; // R8
      end
      flag_set[OVF_BIT]  = wrap;     // R3
      flag_set[EDGE_BIT] = edge_hit; // R7
   end

   // A set in the clearing cycle wins; enables play no part here
   assign nxt_flags = (timer_interrupt_flags_two_ff & ~flag_clear) | flag_set; // R5 R9

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer_interrupt_flags_two_ff <= FLAGS_RST;
      end else begin
         timer_interrupt_flags_two_ff <= nxt_flags;
      end
   end

   // ****************************************
   // Interrupt
   // ****************************************
   // Level stays high until software clears the flag or its enable bit
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (overflow_flag & overflow_irq_enable)       // R5 R6 R12
                | (input_edge_flag & input_edge_irq_enable);  // R9 R10 R13
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_ack_one_cycle: assert property ( // R2
      @(posedge ref_clk) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_answers_req: assert property ( // R2
      @(posedge ref_clk) disable iff (!rstn)
      (req && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   a_count_write: assert property ( // R1
      @(posedge ref_clk) disable iff (!rstn)
      (wr_go && hit_count) |=> (accumulator_count_ff == $past(wb_dat_i[7:0])))
      else $error("count write not stored");

   a_ovf_on_wrap: assert property ( // R3
      @(posedge ref_clk) disable iff (!rstn)
      (count_inc && accumulator_count_ff == 8'hFF && !(wr_go && hit_count))
      |=> (overflow_flag && accumulator_count_ff == 8'h00))
      else $error("wrap did not set overflow");

   a_ovf_clear: assert property ( // R4
      @(posedge ref_clk) disable iff (!rstn)
      (wr_go && hit_flags && wb_dat_i[5] && !wrap) |=> !overflow_flag)
      else $error("overflow not cleared by write of one");

   a_ovf_sticky: assert property ( // R4
      @(posedge ref_clk) disable iff (!rstn)
      (overflow_flag && !(wr_go && hit_flags && wb_dat_i[5])) |=> overflow_flag)
      else $error("overflow flag lost without a clear");

   a_irq_masked: assert property ( // R5
      @(posedge ref_clk) disable iff (!rstn)
      (!(overflow_flag && overflow_irq_enable) && !(input_edge_flag && input_edge_irq_enable))
      |=> !irq_o)
      else $error("interrupt raised with no enabled flag");

   a_irq_ovf: assert property ( // R6
      @(posedge ref_clk) disable iff (!rstn)
      (overflow_flag && overflow_irq_enable) |=> irq_o)
      else $error("enabled overflow raised no interrupt");

   a_edge_flag_set: assert property ( // R7
      @(posedge ref_clk) disable iff (!rstn)
      edge_hit |=> input_edge_flag)
      else $error("selected edge did not set edge flag");

   a_edge_clear: assert property ( // R8
      @(posedge ref_clk) disable iff (!rstn)
      (wr_go && hit_flags && wb_dat_i[4] && !edge_hit) |=> !input_edge_flag)
      else $error("edge flag not cleared by write of one");

   a_irq_edge: assert property ( // R10
      @(posedge ref_clk) disable iff (!rstn)
      (input_edge_flag && input_edge_irq_enable) |=> irq_o)
      else $error("enabled edge raised no interrupt");

   a_disabled_hold: assert property ( // R14
      @(posedge ref_clk) disable iff (!rstn)
      (count_loaded_ff && !accumulator_system_enable && !(wr_go && hit_count))
      |=> (accumulator_count_ff == $past(accumulator_count_ff)) && !$rose(input_edge_flag))
      else $error("disabled accumulator changed");

   a_gated_tick: assert property ( // R16
      @(posedge ref_clk) disable iff (!rstn)
      (count_inc && accumulator_mode_select == MODE_GATED) |-> (gate_tick && gate_open))
      else $error("gated count without tick or open gate");

   a_event_rise: assert property ( // R15
      @(posedge ref_clk) disable iff (!rstn)
      (accumulator_system_enable && accumulator_mode_select == MODE_EVENT
       && edge_polarity_select && $rose(pin_sync)) |-> count_inc)
      else $error("rising edge not counted");

   a_sync_delay: assert property ( // R18
      @(posedge ref_clk) disable iff (!rstn)
      $rose(pin_sync) |-> $past(accumulator_input_pin, 2))
      else $error("input reached logic without two stages");

endmodule : pulse_accumulator_counter

//--- pulse_accumulator_counter_tb_top.sv
`timescale 1ns/1ps
module pulse_accumulator_counter_tb_top;
   import pacc_pkg::*;
   // ****
   // Signals
   // ****
   logic              ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [ADDR_W-1:0] wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [DATA_W-1:0] wb_dat_i, wb_dat_o, rd, seed;
   logic              go, idle_lvl, pin, busy;
   logic [7:0]        n_pulses, cnt, flg, msk, n;
   logic [15:0]       phase_len;
   int                n_fail, check_count;

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   pulse_accumulator_counter pulse_accumulator_counter_inst (
      .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .accumulator_input_pin(pin), .irq_o(irq_o));

   pulse_source pulse_source_inst (
      .ref_clk(ref_clk), .rstn(rstn), .go(go), .n_pulses(n_pulses), .phase_len(phase_len),
      .idle_lvl(idle_lvl), .pin_o(pin), .busy(busy));

   // ****
   // Tasks
   // ****
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Waits on ack with no assumed latency; the watchdog ends a hang
   task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h00_0000, d};
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask : rdchk

   // Six settle cycles cover the three-flop pin path and the irq register
   task automatic pulses(input logic [7:0] np, input logic [15:0] len);
      @(posedge ref_clk);
      n_pulses  <= np;
      phase_len <= len;
      go        <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      do @(posedge ref_clk); while (busy !== 1'b0);
      repeat (6) @(posedge ref_clk);
   endtask : pulses

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial begin
      repeat (40000) @(posedge ref_clk);
      n_fail++;
      finish_test();
   end

   // ****
   // Main sequence
   // ****
   initial begin
      rstn = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = '0;
      wb_sel_i = 4'hF; wb_dat_i = '0; go = 1'b0; idle_lvl = 1'b0; n_pulses = '0;
      phase_len = '0; n_fail = 0; check_count = 0; seed = 32'h0000_86c9;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      rdchk(IDX_MASK, 32'h0000_0000);
      rdchk(IDX_FLAGS, 32'h0000_0000);
      rdchk(6'h10, 32'h0000_0000);
      wb(1'b1, IDX_MASK, 8'hFF);
      rdchk(IDX_MASK, 32'h0000_0030);
      $display("register test done");
      // Falling edges, then rising, then rising across a wrap
      for (int p = 0; p < 3; p++) begin
         seed = lfsr(seed);
         cnt  = (p == 2) ? 8'hFE : seed[7:0];
         n    = 8'(2 + seed[10:8]);
         msk  = (p == 0) ? 8'h00 : (p == 1) ? 8'h10 : 8'h20;
         wb(1'b1, IDX_CTRL, (p > 0) ? 8'h50 : 8'h40);
         wb(1'b1, IDX_MASK, msk);
         wb(1'b1, IDX_FLAGS, 8'h30);
         wb(1'b1, IDX_COUNT, cnt);
         rdchk(IDX_COUNT, {24'h00_0000, cnt});
         pulses(n, 16'(2 + seed[13:11]));
         flg = (({1'b0, cnt} + {1'b0, n}) > 9'h0FF) ? 8'h30 : 8'h10;
         cnt = cnt + n;
         rdchk(IDX_COUNT, {24'h00_0000, cnt});
         rdchk(IDX_FLAGS, {24'h00_0000, flg});
         chk({31'h0, irq_o}, {31'h0, (flg & msk) != 8'h00});
         wb(1'b1, IDX_FLAGS, 8'h00);
         rdchk(IDX_FLAGS, {24'h00_0000, flg});
         wb(1'b1, IDX_FLAGS, 8'h30);
         rdchk(IDX_FLAGS, 32'h0000_0000);
         chk({31'h0, irq_o}, 32'h0000_0000);
      end
      $display("event test done");
      wb(1'b1, IDX_CTRL, 8'h10);
      pulses(8'h03, 16'h0004);
      rdchk(IDX_COUNT, {24'h00_0000, cnt});
      rdchk(IDX_FLAGS, 32'h0000_0000);
      $display("disable test done");
      for (int p = 0; p < 2; p++) begin
         wb(1'b1, IDX_CTRL, 8'h00);
         @(posedge ref_clk);
         idle_lvl <= p[0];
         wb(1'b1, IDX_COUNT, 8'h00);
         wb(1'b1, IDX_CTRL, p[0] ? 8'h70 : 8'h60);
         pulses(8'h01, 16'(10 * GATE_DIV));
         wb(1'b1, IDX_CTRL, 8'h00);
         rdchk(IDX_COUNT, 32'h0000_000A);
      end
      $display("gated test done");
      // Mid-run reset: count must survive, mask and flags must clear
      seed = lfsr(seed);
      wb(1'b1, IDX_COUNT, seed[7:0]);
      wb(1'b1, IDX_MASK, 8'h30);
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      rdchk(IDX_COUNT, {24'h00_0000, seed[7:0]});
      rdchk(IDX_MASK, 32'h0000_0000);
      rdchk(IDX_FLAGS, 32'h0000_0000);
      chk({31'h0, irq_o}, 32'h0000_0000);
      $display("reset test done");
      finish_test();
   end
endmodule : pulse_accumulator_counter_tb_top

//--- pulse_source.sv
`timescale 1ns/1ps
module pulse_source (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Burst request
   input  wire logic        go,
   input  wire logic [7:0]  n_pulses,
   input  wire logic [15:0] phase_len,
   input  wire logic        idle_lvl,
   // Pin and status
   output logic             pin_o,
   output logic             busy
);
   // ****
   // Burst of whole pulses away from the idle level
   // ****
   int len;

   always begin
      @(posedge ref_clk);
      if (rstn && go) begin
         // Never shorter than two clocks a phase, or edges could be lost
         len = (phase_len < 2) ? 2 : int'(phase_len);
         busy <= 1'b1;
         for (int i = 0; i < n_pulses; i++) begin
            pin_o <= ~idle_lvl;
            repeat (len) @(posedge ref_clk);
            pin_o <= idle_lvl;
            repeat (len) @(posedge ref_clk);
         end
         busy <= 1'b0;
      end else begin
         pin_o <= idle_lvl;
         busy  <= 1'b0;
      end
   end
endmodule : pulse_source
